/* File: hw/hbfm_pkg.sv */
// Function
// - hold the fault clear input asserted until supplies are established
// - start-up: raise clear, pulse low-side input to charge bootstrap, drop clear
// - low-side charge pulse and clear pulse each last at least 15 us, unless a sync fault aborts the charge pulse
// - controller may pull the shutdown line low anytime; device does not latch it
// - shutdown line is wired-OR; any low forces all drivers off
package hbfm_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_MHZ  = 125;
  localparam int unsigned MIN_PULSE_NS  = 15000;
  localparam logic [31:0] MIN_PULSE_CYC =
    32'((MIN_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_EVENT  = 12'h008;
  localparam logic [11:0] ADDR_CHARGE = 12'h00C;

  localparam int unsigned CTRL_START_BIT    = 0;
  localparam int unsigned CTRL_SHUTDOWN_BIT = 1;
  localparam int unsigned CTRL_CLEAR_BIT    = 2;
  localparam int unsigned CTRL_HIGH_BIT     = 3;
  localparam int unsigned CTRL_LOW_BIT      = 4;

  localparam int unsigned EVT_FAULT_BIT = 0;
  localparam int unsigned EVT_SYNC_BIT  = 1;
  localparam int unsigned EVT_ABORT_BIT = 2;

  localparam logic [31:0] CHARGE_RESET = MIN_PULSE_CYC;

  typedef enum logic [2:0] {
    HBFM_IDLE, HBFM_CLR_SET, HBFM_CHARGE, HBFM_CHG_OFF,
    HBFM_CLR_REL, HBFM_RUN, HBFM_CLEAR, HBFM_ABORT
  } hbfm_state_t;

endpackage

/* File: hw/hbfm_timer.sv */
module hbfm_timer
  import hbfm_pkg::*;
#(
  parameter int unsigned W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         load,
  input  wire logic [W-1:0] cycles,
  output logic              zero
);

  // ----------------------------------------------------------------
  // down counter
  // ----------------------------------------------------------------
  if (W < 12) begin : g_width_chk
    $error("hbfm_timer: W too small for the minimum pulse");
  end

  logic [W-1:0] count_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= '0;
    end else if (load) begin
      count_r <= cycles;
    end else if (count_r != '0) begin
      count_r <= count_r - W'(1);
    end
  end

  assign zero = (count_r == '0);

endmodule

/* File: hw/hbfm_host.sv */
module hbfm_host
  import hbfm_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             HIGH_SIDE_IN,
  output logic             LOW_SIDE_IN,
  output logic             FAULT_CLEAR_IN,
  input  wire logic        FAULT_SHUTDOWN_LINE_I,
  output logic             FAULT_SHUTDOWN_LINE_O,
  output logic             FAULT_SHUTDOWN_LINE_OE_N,
  input  wire logic        SYNC_FAULT_LINE_N
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic        wr_en;
  logic        rd_setup;
  logic        addr_ok;
  logic        start_pulse;
  logic        clear_pulse;
  logic        sd_r;
  logic        hi_cmd_r;
  logic        low_cmd_r;
  logic [31:0] charge_r;
  logic [2:0]  event_r;
  logic [2:0]  event_nxt;
  logic [31:0] rdata_nxt;

  assign addr_ok  = (PADDR == ADDR_CTRL) || (PADDR == ADDR_STATUS) ||
                    (PADDR == ADDR_EVENT) || (PADDR == ADDR_CHARGE);
  assign wr_en    = PSEL && PENABLE && PWRITE && addr_ok;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign PREADY   = 1'b1;
  assign PSLVERR  = PSEL && PENABLE && !addr_ok;

  assign start_pulse = wr_en && (PADDR == ADDR_CTRL) && PWDATA[CTRL_START_BIT];
  assign clear_pulse = wr_en && (PADDR == ADDR_CTRL) && PWDATA[CTRL_CLEAR_BIT];

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sd_r     <= 1'b0;
      hi_cmd_r <= 1'b0;
      low_cmd_r <= 1'b0;
    end else if (wr_en && (PADDR == ADDR_CTRL)) begin
      sd_r     <= PWDATA[CTRL_SHUTDOWN_BIT];
      hi_cmd_r <= PWDATA[CTRL_HIGH_BIT];
      low_cmd_r <= PWDATA[CTRL_LOW_BIT];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      charge_r <= CHARGE_RESET;
    end else if (wr_en && (PADDR == ADDR_CHARGE)) begin
      charge_r <= PWDATA;
    end
  end

  // ----------------------------------------------------------------
  // start-up and clear sequencer
  // ----------------------------------------------------------------
  hbfm_state_t state_r;
  hbfm_state_t state_nxt;
  logic        tmr_zero;
  logic        tmr_load;
  logic [31:0] tmr_cycles;
  logic [31:0] charge_eff;
  logic        sync_low;
  logic        abort_evt;

  assign sync_low = !SYNC_FAULT_LINE_N;

  // a short charge setting is raised to the floor rather than refused
  assign charge_eff = (charge_r < MIN_PULSE_CYC) ? MIN_PULSE_CYC : charge_r;

  always_comb begin
    state_nxt = state_r;
    abort_evt = 1'b0;
    unique case (state_r)
      HBFM_IDLE: begin
        if (start_pulse) begin
          state_nxt = HBFM_CLR_SET;
        end
      end
      HBFM_CLR_SET: begin
        if (tmr_zero) begin
          state_nxt = HBFM_CHARGE;
        end
      end
      HBFM_CHARGE: begin
        // a sync fault during charging means an inverter failure
        if (sync_low) begin
          state_nxt = HBFM_ABORT;
          abort_evt = 1'b1;
        end else if (tmr_zero) begin
          state_nxt = HBFM_CHG_OFF;
        end
      end
      HBFM_CHG_OFF: begin
        if (sync_low) begin
          state_nxt = HBFM_ABORT;
          abort_evt = 1'b1;
        end else if (tmr_zero) begin
          state_nxt = HBFM_CLR_REL;
        end
      end
      HBFM_CLR_REL: begin
        state_nxt = HBFM_RUN;
      end
      HBFM_RUN: begin
        // clearing while a soft turn-off runs would disturb it
        if (clear_pulse && !sync_low) begin
          state_nxt = HBFM_CLEAR;
        end
      end
      HBFM_CLEAR: begin
        if (tmr_zero) begin
          state_nxt = HBFM_RUN;
        end
      end
      HBFM_ABORT: begin
        if (start_pulse) begin
          state_nxt = HBFM_CLR_SET;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= HBFM_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign tmr_load   = (state_nxt != state_r);
  assign tmr_cycles = (state_nxt == HBFM_CHARGE) ? charge_eff : MIN_PULSE_CYC;

  hbfm_timer #(
    .W (32)
  ) u_timer (
    .clk    (SYS_CLK),
    .rst_b  (RST_B),
    .load   (tmr_load),
    .cycles (tmr_cycles),
    .zero   (tmr_zero)
  );

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  logic hs_nxt;
  logic ls_nxt;
  logic fc_nxt;
  logic run_ok;
  logic sd_nxt;

  // look ahead at the write so the line and the gates change on the same edge
  assign sd_nxt = (wr_en && (PADDR == ADDR_CTRL)) ? PWDATA[CTRL_SHUTDOWN_BIT] : sd_r;

  // shutdown and sequencer both keep the gates off, except the charge pulse drives the low side even with shutdown set
  assign run_ok = (state_nxt == HBFM_RUN) && !sd_nxt;

  always_comb begin
    // clear stays high everywhere but run, so start-up noise raises no fault
    fc_nxt = (state_nxt != HBFM_RUN);
    ls_nxt = (state_nxt == HBFM_CHARGE);
    hs_nxt = 1'b0;
    if (run_ok) begin
      // both commanded is refused here instead of relying on the device
      hs_nxt = hi_cmd_r && !low_cmd_r;
      ls_nxt = low_cmd_r && !hi_cmd_r;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      HIGH_SIDE_IN   <= 1'b0;
      LOW_SIDE_IN    <= 1'b0;
      FAULT_CLEAR_IN <= 1'b1;
    end else begin
      HIGH_SIDE_IN   <= hs_nxt;
      LOW_SIDE_IN    <= ls_nxt;
      FAULT_CLEAR_IN <= fc_nxt;
    end
  end

  // open-drain: only ever pulls low, enable low while driving
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      FAULT_SHUTDOWN_LINE_OE_N <= 1'b1;
    end else begin
      FAULT_SHUTDOWN_LINE_OE_N <= !sd_nxt;
    end
  end

  assign FAULT_SHUTDOWN_LINE_O = 1'b0;

  // ----------------------------------------------------------------
  // events and status
  // ----------------------------------------------------------------
  logic fault_seen;

  // in run, a low line that we are not pulling is a device or peer fault
  assign fault_seen = !FAULT_SHUTDOWN_LINE_I && FAULT_SHUTDOWN_LINE_OE_N &&
                      (state_r == HBFM_RUN);

  always_comb begin
    event_nxt = event_r;
    if (wr_en && (PADDR == ADDR_EVENT)) begin
      event_nxt = event_r & ~PWDATA[2:0];
    end
    // set wins over a clear in the same cycle
    if (fault_seen) event_nxt[EVT_FAULT_BIT] = 1'b1;
    if (sync_low)   event_nxt[EVT_SYNC_BIT]  = 1'b1;
    if (abort_evt)  event_nxt[EVT_ABORT_BIT] = 1'b1;
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      event_r <= 3'h0;
    end else begin
      event_r <= event_nxt;
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (PADDR)
      ADDR_CTRL:   rdata_nxt = {27'h000_0000, low_cmd_r, hi_cmd_r, 1'b0, sd_r, 1'b0};
      ADDR_STATUS: rdata_nxt = {21'h00_0000, 3'(state_r), 3'b000, FAULT_CLEAR_IN,
                                LOW_SIDE_IN, HIGH_SIDE_IN, SYNC_FAULT_LINE_N,
                                FAULT_SHUTDOWN_LINE_I};
      ADDR_EVENT:  rdata_nxt = {29'h0000_0000, event_r};
      ADDR_CHARGE: rdata_nxt = charge_r;
      default:     rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_setup) begin
      PRDATA <= rdata_nxt;
    end
  end

endmodule

/* File: tb/hbfm_host_chk.sv */
module hbfm_chk
  import hbfm_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic HIGH_SIDE_IN,
  input wire logic LOW_SIDE_IN,
  input wire logic FAULT_CLEAR_IN,
  input wire logic FAULT_SHUTDOWN_LINE_O,
  input wire logic FAULT_SHUTDOWN_LINE_OE_N
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_r;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  // ------
  // start-up order and shutdown line
  // ------
  // saturates, so a long idle clear never wraps to a short count
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= FAULT_CLEAR_IN ? cnt_r + {15'h0000, ~&cnt_r} : 16'h0000;
    end
  end
  reset_out_a: assert property (
    $rose(RST_B) |-> FAULT_CLEAR_IN && !HIGH_SIDE_IN && !LOW_SIDE_IN)
    else $error("outputs wrong after reset release");
  charge_after_a: assert property (
    $rose(LOW_SIDE_IN) && FAULT_CLEAR_IN |-> {16'h0000, cnt_r} >= MIN_PULSE_CYC)
    else $error("charge began before clear stood long enough");
  clear_gate_a: assert property (
    FAULT_CLEAR_IN |-> !HIGH_SIDE_IN)
    else $error("high input raised while clear high");
  clear_len_a: assert property (
    $fell(FAULT_CLEAR_IN) |-> {16'h0000, cnt_r} >= MIN_PULSE_CYC && !$past(LOW_SIDE_IN))
    else $error("clear pulse too short or charge still on");
  sd_gates_a: assert property (
    !FAULT_SHUTDOWN_LINE_OE_N |-> !HIGH_SIDE_IN && !LOW_SIDE_IN)
    else $error("gate input high during own shutdown");
  open_drain_a: assert property (
    FAULT_SHUTDOWN_LINE_O == 1'b0)
    else $error("shutdown line driven high");
endmodule

/* File: tb/hbfm_drv_model.sv */
module hbfm_drv_model #(
  parameter int SOFT_CYC = 40,
  parameter int QUAL_CYC = 6
) (
  input  wire logic clk,
  input  wire logic hin,
  input  wire logic lin,
  input  wire logic clr,
  input  wire logic sd_line,
  input  wire logic desat,
  input  wire logic uv,
  input  wire logic fuv,
  output logic      sd_pull_n,
  output logic      sync_pull_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int   soft_cnt = 0;
  int   qual_cnt = 0;
  logic latched = 1'b0;
  logic high_gate = 1'b0;
  logic low_gate = 1'b0;
  logic hin_q = 1'b0;
  logic high_arm = 1'b1;
  // ------
  // gate driver behaviour
  // ------
  always @(posedge clk) begin
    hin_q <= hin;
    if (fuv) begin
      high_arm <= 1'b0;
    end else if (hin && !hin_q) begin
      high_arm <= 1'b1;
    end
    qual_cnt <= (desat && (high_gate || low_gate)) ? qual_cnt + 1 : 0;
    if (soft_cnt > 0) begin
      soft_cnt <= soft_cnt - 1;
      latched <= latched || (soft_cnt == 1 && !clr);
    end else if (qual_cnt >= QUAL_CYC) begin
      soft_cnt <= SOFT_CYC;
    end else if (clr) begin
      latched <= 1'b0;
    end
    if (soft_cnt > 0 || !sd_line || uv) begin
      high_gate <= 1'b0;
      low_gate <= 1'b0;
    end else if (sync_pull_n) begin
      high_gate <= hin && !lin && !fuv && (high_arm || !hin_q);
      low_gate <= lin && !hin;
    end
  end
  assign sync_pull_n = (soft_cnt == 0);
  assign sd_pull_n   = !latched && !uv;
endmodule

/* File: tb/test_hbfm_host.sv */
module test_hbfm_host
  import hbfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] pad = 12'h000;
  logic [31:0] pwd = 32'h0000_0000;
  logic        desat = 1'b0;
  logic        uv = 1'b0;
  logic        fuv = 1'b0;
  logic        ext_n = 1'b1;
  logic [31:0] prd, rd, chg;
  logic        prdy, perr, err, hin, lin, clr, oe_n, pull_n, sync_n;
  wire         line = oe_n & pull_n & ext_n;
  int          failures = 0;
  int          comparisons = 0;
  int          n, m_st, m_hi, m_clr, m_line;

  hbfm_host u_dut (.SYS_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pad), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .HIGH_SIDE_IN(hin), .LOW_SIDE_IN(lin), .FAULT_CLEAR_IN(clr), .FAULT_SHUTDOWN_LINE_I(line),
    .FAULT_SHUTDOWN_LINE_O(), .FAULT_SHUTDOWN_LINE_OE_N(oe_n), .SYNC_FAULT_LINE_N(sync_n));
  hbfm_drv_model u_drv (.clk(clk), .hin(hin), .lin(lin), .clr(clr), .sd_line(line),
    .desat(desat), .uv(uv), .fuv(fuv), .sd_pull_n(pull_n), .sync_pull_n(sync_n));

  initial forever #4 clk = ~clk;
  initial begin
    #400000;
    failures++;
    complete_run();
  end
  // ------
  // bus, model and checks
  // ------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    pad <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) begin
      @(posedge clk);
    end
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  function automatic logic [31:0] exp_st();
    return {21'h0, m_st[2:0], 3'h0, m_clr[0], 1'b0, m_hi[0], 1'b1, m_line[0]};
  endfunction
  // bounded, so a stuck pin ends in a failed compare, not a hang
  task automatic wait_pin(input int k, input logic v);
    n = 0;
    while ((k == 0 ? lin : k == 1 ? clr : sync_n) !== v && n < 8000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    m_st = 0;
    m_hi = 0;
    m_clr = 1;
    m_line = 1;
  endtask
  task automatic desat_pulse();
    desat <= 1'b1;
    wait_pin(2, 1'b0);
    desat <= 1'b0;
    wait_pin(2, 1'b1);
  endtask
  task automatic start_up(input logic abort);
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    wait_pin(0, 1'b1);
    chk("clear in charge", 32'h1, {31'h0, clr});
    if (abort) begin
      desat_pulse();
      m_st = 7;
      rd_chk("event", ADDR_EVENT, 32'h0000_0006);
      apb(1'b1, ADDR_EVENT, 32'h0000_0007);
    end else begin
      wait_pin(0, 1'b0);
      chk("charge length", 32'h1, {31'h0, n >= MIN_PULSE_CYC && n <= chg + 2});
      wait_pin(1, 1'b0);
      m_st = 5;
      m_clr = 0;
    end
    rd_chk("status", ADDR_STATUS, exp_st());
  endtask
  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ------
  // scenarios
  // ------
  initial begin
    void'($urandom(32'h0331_926c));
    do_reset();
    chg = MIN_PULSE_CYC + ($urandom % 64);
    rd_chk("status", ADDR_STATUS, exp_st());
    rd_chk("charge", ADDR_CHARGE, CHARGE_RESET);
    rd_chk("unmapped", 12'h010, 32'h0000_0000);
    chk("slave error", 32'h1, {31'h0, err});
    apb(1'b1, ADDR_CHARGE, chg);
    start_up(1'b1);
    start_up(1'b0);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ADDR_CTRL, 32'(k) << 3);
      m_hi = (k == 1);
      // the gate pins follow the command register one edge after the write lands
      repeat (2) @(posedge clk);
      chk("gates", {30'h0, k == 2, k == 1}, {30'h0, lin, hin});
    end
    apb(1'b1, ADDR_CTRL, 32'h0000_000a);
    m_hi = 0;
    m_line = 0;
    rd_chk("status", ADDR_STATUS, exp_st());
    apb(1'b1, ADDR_CTRL, 32'h0000_0008);
    m_hi = 1;
    m_line = 1;
    rd_chk("status", ADDR_STATUS, exp_st());
    for (int k = 0; k < 3; k++) begin
      uv <= (k == 0);
      ext_n <= (k != 1);
      fuv <= (k == 2);
      repeat (10) @(posedge clk);
      uv <= 1'b0;
      ext_n <= 1'b1;
      fuv <= 1'b0;
      rd_chk("event", ADDR_EVENT, {31'h0, k != 2});
      apb(1'b1, ADDR_EVENT, 32'h0000_0001);
    end
    // the high gate needs a fresh rising input after the floating supply dip
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, ADDR_CTRL, 32'h0000_0008);
    desat_pulse();
    rd_chk("event", ADDR_EVENT, 32'h0000_0003);
    apb(1'b1, ADDR_CTRL, 32'h0000_0004);
    wait_pin(1, 1'b1);
    wait_pin(1, 1'b0);
    m_hi = 0;
    rd_chk("status", ADDR_STATUS, exp_st());
    apb(1'b1, ADDR_EVENT, 32'h0000_0003);
    rd_chk("event", ADDR_EVENT, 32'h0000_0000);
    do_reset();
    rd_chk("status", ADDR_STATUS, exp_st());
    complete_run();
  end
endmodule

bind hbfm_host hbfm_chk u_chk (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .HIGH_SIDE_IN(HIGH_SIDE_IN),
  .LOW_SIDE_IN(LOW_SIDE_IN), .FAULT_CLEAR_IN(FAULT_CLEAR_IN),
  .FAULT_SHUTDOWN_LINE_O(FAULT_SHUTDOWN_LINE_O),
  .FAULT_SHUTDOWN_LINE_OE_N(FAULT_SHUTDOWN_LINE_OE_N));
